// [src/wdtc_counter.v]
// Watchdog 19-bit up-counter with interval tap and reset-delay counter.
// Assumes it runs on the watchdog clock, with clear held by the caller.
`timescale 1ns/1ns
`include "wdtc_map.vh"

module wdtc_counter (
   input  wire                     ref_clk,
   input  wire                     rst,
   input  wire                     run,
   input  wire                     clear,
   input  wire [2:0]               interval_select,
   output reg                      timeout_hit,
   output reg                      delay_done
);

   reg  [`WDTC_CNT_W-1:0]  count_q;
   reg  [`WDTC_DLY_W-1:0]  delay_q;
   reg                     armed_q;
   wire [4:0]              tap;
   wire                    reach;

   // Interval 2^(4+2*sel); reached when the counter hits exactly that value
   assign tap   = {1'b0, interval_select, 1'b0} + 5'h04;
   assign reach = (count_q == ({{(`WDTC_CNT_W-1){1'b0}}, 1'b1} << tap));

   // ********************************************************************
   // Counting
   // ********************************************************************
   always @(posedge ref_clk) begin
      if (rst || clear || !run) begin
         count_q     <= {`WDTC_CNT_W{1'b0}};
         delay_q     <= {`WDTC_DLY_W{1'b0}};
         armed_q     <= 1'b0;
         timeout_hit <= 1'b0;
         delay_done  <= 1'b0;
      end else begin
         count_q     <= count_q + 1'b1;
         timeout_hit <= reach && !armed_q;
         delay_done  <= 1'b0;
         if (reach && !armed_q) begin
            armed_q <= 1'b1;
         end
         // Delay counted separately so wrap of the main counter is harmless
         if (armed_q) begin
            if (delay_q == `WDTC_RST_DELAY - 1'b1) begin
               delay_done <= 1'b1;
               armed_q    <= 1'b0;
               delay_q    <= {`WDTC_DLY_W{1'b0}};
            end else begin
               delay_q <= delay_q + 1'b1;
            end
         end
      end
   end

endmodule

// [src/wdtc_map.vh]
// Register map, field positions, reset values and timing counts of the
// watchdog timer control block. Included by every design file.
`ifndef WDTC_MAP_VH
`define WDTC_MAP_VH

// ********************************************************************
// Register offsets (byte addresses)
// ********************************************************************
`define WDTC_ADDR_CTRL       8'h00
`define WDTC_ADDR_IRQ_STAT   8'h04
`define WDTC_ADDR_IRQ_MASK   8'h08
`define WDTC_ADDR_LOCK       8'h0C
`define WDTC_ADDR_W          8

// ********************************************************************
// Control register fields
// ********************************************************************
`define WDTC_F_SEL_HI        10
`define WDTC_F_SEL_LO        8
`define WDTC_F_EN            7
`define WDTC_F_IRQ_EN        6
`define WDTC_F_WAKE_FLAG     5
`define WDTC_F_WAKE_EN       4
`define WDTC_F_TO_FLAG       3
`define WDTC_F_RST_FLAG      2
`define WDTC_F_RST_EN        1
`define WDTC_F_CLR           0
`define WDTC_CTRL_RESET      32'h0000_0700
`define WDTC_SEL_RESET       3'h7

// ********************************************************************
// Event status / mask fields
// ********************************************************************
`define WDTC_EV_TIMEOUT      0
`define WDTC_EV_WAKE         1
`define WDTC_EV_RESET        2
`define WDTC_EV_W            3

// ********************************************************************
// Unlock sequence and timing
// ********************************************************************
`define WDTC_UNLOCK_KEY0     8'h59
`define WDTC_UNLOCK_KEY1     8'h16
`define WDTC_UNLOCK_KEY2     8'h88
`define WDTC_CNT_W           19
`define WDTC_RST_DELAY       11'h400
`define WDTC_DLY_W           11
`define WDTC_RST_HOLD        7'h40
`define WDTC_HOLD_W          7
`define WDTC_CLR_TICKS       2'h2

`endif

// [src/wdtc_top.v]
// Watchdog timer control block: control register with unlock-protected settings (flags clear without unlock) on a classic
// Wishbone slave, time-out and reset logic, event interrupt.
// Assumes ref_clk is the watchdog clock, sleep_mode comes from another
// clock domain, and the chip reset logic holds rst away from this block's
// flags while it applies wdt_reset_out (so the reset flag survives).
`timescale 1ns/1ns
`include "wdtc_map.vh"

module wdtc_top (
   input  wire                     ref_clk,
   input  wire                     rst,
   input  wire                     wb_cyc_i,
   input  wire                     wb_stb_i,
   input  wire                     wb_we_i,
   input  wire [`WDTC_ADDR_W-1:0]  wb_adr_i,
   input  wire [3:0]               wb_sel_i,
   input  wire [31:0]              wb_dat_i,
   output reg  [31:0]              wb_dat_o,
   output reg                      wb_ack_o,
   input  wire                     sleep_mode,
   output reg                      timeout_irq,
   output reg                      wakeup_trigger,
   output reg                      wdt_reset_out,
   output reg                      irq
);

   reg  [2:0]              interval_select_q;
   reg                     watchdog_enable_q;
   reg                     timeout_irq_enable_q;
   reg                     wakeup_flag_q;
   reg                     wakeup_enable_q;
   reg                     timeout_flag_q;
   reg                     reset_flag_q;
   reg                     reset_enable_q;
   reg                     counter_clear_q;
   reg  [1:0]              clr_cnt_q;
   reg  [1:0]              unlock_step_q;
   reg                     unlocked_q;
   reg  [`WDTC_EV_W-1:0]   ev_stat_q;
   reg  [`WDTC_EV_W-1:0]   ev_mask_q;
   reg  [`WDTC_HOLD_W-1:0] hold_q;
   reg                     sleep_s1_q;
   reg                     sleep_s2_q;
   wire                    timeout_hit;
   wire                    delay_done;
   wire                    wr;
   wire                    rd;
   wire                    wr_lo;
   wire                    wr_hi;
   wire                    wake_evt;
   wire                    rst_evt;
   wire [`WDTC_EV_W-1:0]   ev_set;
   reg  [31:0]             ctrl_view;
   reg  [31:0]             rd_d;

   // ********************************************************************
   // Counter
   // ********************************************************************
   wdtc_counter u_counter (
      .ref_clk         (ref_clk),
      .rst             (rst),
      .run             (watchdog_enable_q),
      .clear           (counter_clear_q),
      .interval_select (interval_select_q),
      .timeout_hit     (timeout_hit),
      .delay_done      (delay_done)
   );

   // ********************************************************************
   // Bus decode
   // ********************************************************************
   // Answer one cycle after the request; ack drops the cycle after.
   // Writes land at the edge where the master samples ack high.
   assign wr    = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o;
   assign rd    = wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o;
   assign wr_lo = wr && wb_sel_i[0];
   assign wr_hi = wr && wb_sel_i[1];

   assign wake_evt = timeout_hit && sleep_s2_q && timeout_irq_enable_q
                     && wakeup_enable_q;
   assign rst_evt  = delay_done && reset_enable_q;
   assign ev_set   = {rst_evt, wake_evt, timeout_hit};

   always @* begin
      ctrl_view = 32'h0000_0000;
      ctrl_view[`WDTC_F_SEL_HI:`WDTC_F_SEL_LO] = interval_select_q;
      ctrl_view[`WDTC_F_EN]        = watchdog_enable_q;
      ctrl_view[`WDTC_F_IRQ_EN]    = timeout_irq_enable_q;
      ctrl_view[`WDTC_F_WAKE_FLAG] = wakeup_flag_q;
      ctrl_view[`WDTC_F_WAKE_EN]   = wakeup_enable_q;
      ctrl_view[`WDTC_F_TO_FLAG]   = timeout_flag_q;
      ctrl_view[`WDTC_F_RST_FLAG]  = reset_flag_q;
      ctrl_view[`WDTC_F_RST_EN]    = reset_enable_q;
      ctrl_view[`WDTC_F_CLR]       = counter_clear_q;
   end

   always @* begin
      case (wb_adr_i)
         `WDTC_ADDR_CTRL:     rd_d = ctrl_view;
         `WDTC_ADDR_IRQ_STAT: rd_d = {29'h0000_0000, ev_stat_q};
         `WDTC_ADDR_IRQ_MASK: rd_d = {29'h0000_0000, ev_mask_q};
         `WDTC_ADDR_LOCK:     rd_d = {31'h0000_0000, unlocked_q};
         default:             rd_d = 32'h0000_0000;
      endcase
   end

   always @(posedge ref_clk) begin
      if (rst) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
      end else begin
         wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
         wb_dat_o <= rd ? rd_d : 32'h0000_0000;
      end
   end

   // ********************************************************************
   // Unlock sequence
   // ********************************************************************
   // Three key bytes in order unlock; any other byte or a write to
   // the lock register while unlocked locks again.
   localparam [1:0] UNL_IDLE = 2'h0;
   localparam [1:0] UNL_KEY1 = 2'h1;
   localparam [1:0] UNL_KEY2 = 2'h2;

   always @(posedge ref_clk) begin
      if (rst) begin
         unlock_step_q <= UNL_IDLE;
         unlocked_q    <= 1'b0;
      end else if (wr_lo && wb_adr_i == `WDTC_ADDR_LOCK) begin
         // Any write here relocks; only the expected key advances
         unlocked_q    <= 1'b0;
         unlock_step_q <= UNL_IDLE;
         case (unlock_step_q)
            UNL_KEY1: begin
               if (wb_dat_i[7:0] == `WDTC_UNLOCK_KEY1) begin
                  unlock_step_q <= UNL_KEY2;
               end
            end
            UNL_KEY2: begin
               if (wb_dat_i[7:0] == `WDTC_UNLOCK_KEY2) begin
                  unlocked_q <= 1'b1;
               end
            end
            default: begin
            end
         endcase
         // First key restarts the sequence from any step
         if (wb_dat_i[7:0] == `WDTC_UNLOCK_KEY0) begin
            unlock_step_q <= UNL_KEY1;
         end
      end
   end

   // ********************************************************************
   // Control register
   // ********************************************************************
   always @(posedge ref_clk) begin
      if (rst) begin
         sleep_s1_q <= 1'b0;
         sleep_s2_q <= 1'b0;
      end else begin
         sleep_s1_q <= sleep_mode;
         sleep_s2_q <= sleep_s1_q;
      end
   end

   always @(posedge ref_clk) begin
      if (rst) begin
         interval_select_q    <= `WDTC_SEL_RESET;
         watchdog_enable_q    <= 1'b0;
         timeout_irq_enable_q <= 1'b0;
         wakeup_enable_q      <= 1'b0;
         reset_enable_q       <= 1'b0;
         counter_clear_q      <= 1'b0;
         clr_cnt_q            <= 2'h0;
      end else begin
         if (wr && unlocked_q && wb_adr_i == `WDTC_ADDR_CTRL) begin
            if (wb_sel_i[1]) begin
               interval_select_q <= wb_dat_i[`WDTC_F_SEL_HI:`WDTC_F_SEL_LO];
            end
            if (wb_sel_i[0]) begin
               watchdog_enable_q    <= wb_dat_i[`WDTC_F_EN];
               timeout_irq_enable_q <= wb_dat_i[`WDTC_F_IRQ_EN];
               wakeup_enable_q      <= wb_dat_i[`WDTC_F_WAKE_EN];
               reset_enable_q       <= wb_dat_i[`WDTC_F_RST_EN];
               if (wb_dat_i[`WDTC_F_CLR]) begin
                  counter_clear_q <= 1'b1;
                  clr_cnt_q       <= `WDTC_CLR_TICKS;
               end
            end
         end else if (counter_clear_q) begin
            // Held a couple of cycles so the counter sees it, then drops
            if (clr_cnt_q == 2'h0) begin
               counter_clear_q <= 1'b0;
            end else begin
               clr_cnt_q <= clr_cnt_q - 1'b1;
            end
         end
      end
   end

   // ********************************************************************
   // Flags: set wins over write-1 clear
   // ********************************************************************
   // Reset flag is cleared only by software: the watchdog reset output
   // does not touch it, and chip logic must keep rst off this block.
   always @(posedge ref_clk) begin
      if (rst) begin
         timeout_flag_q <= 1'b0;
         reset_flag_q   <= 1'b0;
         wakeup_flag_q  <= 1'b0;
      end else begin
         if (timeout_hit) begin
            timeout_flag_q <= 1'b1;
         end else if (wr_lo && wb_adr_i == `WDTC_ADDR_CTRL &&
                      wb_dat_i[`WDTC_F_TO_FLAG]) begin
            timeout_flag_q <= 1'b0;
         end
         if (rst_evt) begin
            reset_flag_q <= 1'b1;
         end else if (wr_lo && wb_adr_i == `WDTC_ADDR_CTRL &&
                      wb_dat_i[`WDTC_F_RST_FLAG]) begin
            reset_flag_q <= 1'b0;
         end
         if (wake_evt) begin
            wakeup_flag_q <= 1'b1;
         end else if (wr_lo && wb_adr_i == `WDTC_ADDR_CTRL &&
                      wb_dat_i[`WDTC_F_WAKE_FLAG]) begin
            wakeup_flag_q <= 1'b0;
         end
      end
   end

   // ********************************************************************
   // Event status and interrupt
   // ********************************************************************
   genvar gi;
   generate
      for (gi = 0; gi < `WDTC_EV_W; gi = gi + 1) begin : g_ev
         always @(posedge ref_clk) begin
            if (rst) begin
               ev_stat_q[gi] <= 1'b0;
               ev_mask_q[gi] <= 1'b0;
            end else begin
               if (ev_set[gi]) begin
                  ev_stat_q[gi] <= 1'b1;
               end else if (wr_lo && wb_adr_i == `WDTC_ADDR_IRQ_STAT &&
                            wb_dat_i[gi]) begin
                  ev_stat_q[gi] <= 1'b0;
               end
               if (wr_lo && wb_adr_i == `WDTC_ADDR_IRQ_MASK) begin
                  ev_mask_q[gi] <= wb_dat_i[gi];
               end
            end
         end
      end
   endgenerate

   // ********************************************************************
   // Outputs
   // ********************************************************************
   always @(posedge ref_clk) begin
      if (rst) begin
         timeout_irq    <= 1'b0;
         wakeup_trigger <= 1'b0;
         irq            <= 1'b0;
      end else begin
         timeout_irq    <= timeout_flag_q && timeout_irq_enable_q;
         wakeup_trigger <= wakeup_enable_q && timeout_flag_q
                           && timeout_irq_enable_q;
         irq            <= |(ev_stat_q & ev_mask_q);
      end
   end

   // Reset pulse: exactly 64 clocks, re-armed only by a new event
   always @(posedge ref_clk) begin
      if (rst) begin
         hold_q        <= {`WDTC_HOLD_W{1'b0}};
         wdt_reset_out <= 1'b0;
      end else if (rst_evt) begin
         hold_q        <= `WDTC_RST_HOLD - 1'b1;
         wdt_reset_out <= 1'b1;
      end else if (hold_q != {`WDTC_HOLD_W{1'b0}}) begin
         hold_q <= hold_q - 1'b1;
      end else begin
         wdt_reset_out <= 1'b0;
      end
   end

endmodule

// [test/watchdog_timer_control_tb.sv]
// Self-checking bench of the watchdog block through its Wishbone port.
// Assumes the far-side model and the bound checker are compiled first.
`timescale 1ns/1ns
module watchdog_timer_control_tb;
   logic        ref_clk, rst, cyc, stb, we, sleep_req, seen;
   logic [7:0]  adr, nres;
   logic [31:0] dat, q;
   wire  [31:0] dat_o;
   wire         ack, sleep_mode, to_irq, wake, wrst, irq;
   wire  [6:0]  rlen;
   wire  [7:0]  rnum;
   int          fails, checked, n;

   wdtc_top i_dut (
      .ref_clk(ref_clk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(dat),
      .wb_dat_o(dat_o), .wb_ack_o(ack), .sleep_mode(sleep_mode),
      .timeout_irq(to_irq), .wakeup_trigger(wake),
      .wdt_reset_out(wrst), .irq(irq));
   wdtc_far_model i_far (
      .ref_clk(ref_clk), .rst(rst), .sleep_req(sleep_req),
      .wdt_reset_out(wrst), .wakeup_trigger(wake),
      .sleep_mode(sleep_mode), .rst_len(rlen), .rst_num(rnum));

   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end
   // ********************
   // Bus and compare helpers
   // ********************
   task automatic wb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
      @(posedge ref_clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we  <= w;
      adr <= a;
      dat <= d;
      // Only the watchdog process ends a wait that never gets an answer
      do begin
         @(posedge ref_clk);
      end while (ack !== 1'b1);
      q = dat_o;
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask
   task automatic cmp(input logic [31:0] g, input logic [31:0] e);
      checked++;
      if (g !== e) begin
         fails++;
         $display("unexpected at %0t: got %h, expected %h", $time, g, e);
      end
   endtask
   task automatic rng(input int v, input int lo, input int hi);
      checked++;
      if (v < lo || v > hi) begin
         fails++;
         $display("unexpected at %0t: got %h, limits %h %h",
                  $time, v, lo, hi);
      end
   endtask
   task automatic reg_is(input logic [7:0] a, input logic [31:0] e);
      wb(1'b0, a, 32'h0000_0000);
      cmp(q, e);
   endtask
   task automatic unlock;
      wb(1'b1, 8'h0C, 32'h0000_0059);
      wb(1'b1, 8'h0C, 32'h0000_0016);
      wb(1'b1, 8'h0C, 32'h0000_0088);
   endtask
   // Bounded wait on 0 time-out request, 1 reset pulse, 2 wake trigger
   task automatic wait_on(input int s, input int lim);
      n = 0;
      while (((s == 0) ? to_irq : (s == 1) ? wrst : wake) !== 1'b1
             && n < lim) begin
         @(posedge ref_clk);
         n++;
      end
   endtask
   task automatic idle(input int c);
      repeat (c) begin
         @(posedge ref_clk);
         if (to_irq !== 1'b0) seen = 1'b1;
      end
   endtask
   // ********************
   // Scenarios
   // ********************
   task automatic t_lock;
      reg_is(8'h00, 32'h0000_0700);
      reg_is(8'h40, 32'h0000_0000);
      wb(1'b1, 8'h00, 32'h0000_00C2);
      reg_is(8'h00, 32'h0000_0700);
      unlock();
      reg_is(8'h0C, 32'h0000_0001);
   endtask
   task automatic t_reset_path;
      wb(1'b1, 8'h00, 32'h0000_00C2);
      wait_on(0, 60);
      rng(n, 16, 22);
      wait_on(1, 1100);
      rng(n, 1018, 1030);
      repeat (70) @(posedge ref_clk);
      cmp({25'h000_0000, rlen}, 32'h0000_0040);
      reg_is(8'h00, 32'h0000_00CE);
      reg_is(8'h04, 32'h0000_0005);
      wb(1'b1, 8'h08, 32'h0000_0004);
      repeat (3) @(posedge ref_clk);
      cmp({31'h0000_0000, irq}, 32'h0000_0001);
      wb(1'b1, 8'h04, 32'h0000_0005);
      repeat (3) @(posedge ref_clk);
      cmp({31'h0000_0000, irq}, 32'h0000_0000);
      wb(1'b1, 8'h08, 32'h0000_0000);
      wb(1'b1, 8'h0C, 32'h0000_0000);
      wb(1'b1, 8'h00, 32'h0000_000C);
      reg_is(8'h00, 32'h0000_00C2);
      unlock();
      wb(1'b1, 8'h00, 32'h0000_0000);
   endtask
   task automatic t_clear;
      wb(1'b1, 8'h00, 32'h0000_01C2);
      repeat (40) @(posedge ref_clk);
      wb(1'b1, 8'h00, 32'h0000_0142);
      wb(1'b1, 8'h00, 32'h0000_01C2);
      wait_on(0, 100);
      rng(n, 64, 70);
      nres = rnum;
      wb(1'b1, 8'h00, 32'h0000_01CB);
      // Request output trails the flag clear by a registered stage
      repeat (2) @(posedge ref_clk);
      seen = 1'b0;
      repeat (5) begin
         idle(40);
         wb(1'b1, 8'h00, 32'h0000_01C3);
      end
      cmp({31'h0000_0000, seen}, 32'h0000_0000);
      cmp({24'h00_0000, rnum}, {24'h00_0000, nres});
      wait_on(0, 100);
      rng(n, 64, 72);
      reg_is(8'h00, 32'h0000_01CA);
      wb(1'b1, 8'h00, 32'h0000_0008);
   endtask
   task automatic t_quiet;
      nres = rnum;
      wb(1'b1, 8'h00, 32'h0000_0090);
      seen = 1'b0;
      idle(1200);
      cmp({31'h0000_0000, seen}, 32'h0000_0000);
      cmp({24'h00_0000, rnum}, {24'h00_0000, nres});
      reg_is(8'h00, 32'h0000_0098);
      wb(1'b1, 8'h00, 32'h0000_0008);
   endtask
   task automatic t_wake;
      sleep_req <= 1'b1;
      repeat (4) @(posedge ref_clk);
      wb(1'b1, 8'h00, 32'h0000_00D0);
      wait_on(2, 60);
      rng(n, 16, 24);
      reg_is(8'h00, 32'h0000_00F8);
      wb(1'b1, 8'h00, 32'h0000_0028);
      sleep_req <= 1'b0;
   endtask
   task automatic print_verdict;
      if (fails == 0 && checked > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask

   initial begin
      rst = 1'b1;
      cyc = 1'b0;
      stb = 1'b0;
      we = 1'b0;
      adr = 8'h00;
      dat = 32'h0000_0000;
      sleep_req = 1'b0;
      seen = 1'b0;
      nres = 8'h00;
      fails = 0;
      checked = 0;
      repeat (2) @(posedge ref_clk);
      rst <= 1'b0;
      t_lock();
      t_reset_path();
      t_clear();
      t_quiet();
      t_wake();
      print_verdict();
   end
   // The tests need about 2800 cycles; a hang is cut well beyond that
   initial begin
      repeat (20000) @(posedge ref_clk);
      fails++;
      print_verdict();
   end
endmodule

// [test/wdtc_assertions.sv]
// Checker for the watchdog block: bus handshake, reset pulse, requests.
// Assumes one clock, ref_clk, and a synchronous active-high rst.
`timescale 1ns/1ns
module wdtc_checker (
   input logic        ref_clk,
   input logic        rst,
   input logic        wb_cyc_i,
   input logic        wb_stb_i,
   input logic        wb_we_i,
   input logic [31:0] wb_dat_o,
   input logic        wb_ack_o,
   input logic        timeout_irq,
   input logic        wakeup_trigger,
   input logic        wdt_reset_out,
   input logic        irq
);
   logic [6:0] hold_q;
   logic       wr_req;
   assign wr_req = wb_cyc_i & wb_stb_i & wb_we_i;
   // Length of the current reset pulse, read when it ends
   always @(posedge ref_clk) begin
      if (rst || !wdt_reset_out) begin
         hold_q <= 7'h00;
      end else begin
         hold_q <= hold_q + 7'h01;
      end
   end
   default clocking @(posedge ref_clk); endclocking
   default disable iff (rst);
   sequence s_req;
      wb_cyc_i && wb_stb_i && !wb_ack_o;
   endsequence
   property p_ack_req;
      s_req |=> wb_ack_o;
   endproperty
   a_ack_req: assert property (p_ack_req) else $error("ack missing");
   property p_ack_pulse;
      wb_ack_o |=> !wb_ack_o;
   endproperty
   a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");
   property p_ack_cause;
      $rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i);
   endproperty
   a_ack_cause: assert property (p_ack_cause) else $error("ack unasked");
   property p_dat_zero;
      !wb_ack_o |-> wb_dat_o == 32'h0000_0000;
   endproperty
   a_dat_zero: assert property (p_dat_zero) else $error("data off ack");
   property p_rst_len;
      $fell(wdt_reset_out) |-> hold_q == 7'h40;
   endproperty
   a_rst_len: assert property (p_rst_len) else $error("reset length");
   property p_wake;
      wakeup_trigger |-> timeout_irq;
   endproperty
   a_wake: assert property (p_wake) else $error("wake without request");
   // Only software clears the flag, so a drop needs a recent write
   property p_irq_keep;
      $fell(timeout_irq) |-> $past(wr_req) || $past(wr_req, 2)
         || $past(wr_req, 3);
   endproperty
   a_irq_keep: assert property (p_irq_keep) else $error("request lost");
   property p_quiet;
      disable iff (1'b0) rst |=> !wdt_reset_out && !timeout_irq && !irq
         && !wb_ack_o;
   endproperty
   a_quiet: assert property (p_quiet) else $error("outputs live in reset");
endmodule

bind wdtc_top wdtc_checker i_chk (
   .ref_clk(ref_clk), .rst(rst), .wb_cyc_i(wb_cyc_i),
   .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_dat_o(wb_dat_o),
   .wb_ack_o(wb_ack_o), .timeout_irq(timeout_irq),
   .wakeup_trigger(wakeup_trigger), .wdt_reset_out(wdt_reset_out),
   .irq(irq)
);

// [test/wdtc_far_model.sv]
// Far side: chip reset generator and CPU sleep and wake-up logic.
// Assumes the reset pulse is never fed back into the block's own rst.
`timescale 1ns/1ns
module wdtc_far_model (
   input  logic       ref_clk,
   input  logic       rst,
   input  logic       sleep_req,
   input  logic       wdt_reset_out,
   input  logic       wakeup_trigger,
   output logic       sleep_mode,
   output logic [6:0] rst_len,
   output logic [7:0] rst_num
);
   logic [6:0] cnt_q;
   logic       woke_q;
   // Clocked from the fast clock, not a 32k crystal, so reset is usable
   always @(posedge ref_clk) begin
      if (rst) begin
         cnt_q   <= 7'h00;
         rst_len <= 7'h00;
         rst_num <= 8'h00;
      end else if (wdt_reset_out) begin
         cnt_q <= cnt_q + 7'h01;
      end else if (cnt_q != 7'h00) begin
         rst_len <= cnt_q;
         rst_num <= rst_num + 8'h01;
         cnt_q   <= 7'h00;
      end
   end
   // The CPU stays awake until it is sent to sleep again
   always @(posedge ref_clk) begin
      if (rst || !sleep_req) begin
         woke_q <= 1'b0;
      end else if (wakeup_trigger) begin
         woke_q <= 1'b1;
      end
   end
   assign sleep_mode = sleep_req && !woke_q;
endmodule
